// File: design/dras_consts.svh
`ifndef DRAS_CONSTS_SVH
`define DRAS_CONSTS_SVH

// register byte offsets
`define DRAS_OFF_CTRL 8'h00
`define DRAS_OFF_LIMIT 8'h04
`define DRAS_OFF_LSEC 8'h08
`define DRAS_OFF_GEOM 8'h0c
`define DRAS_OFF_STATUS 8'h10
`define DRAS_OFF_RETRY 8'h14

// control register fields
`define DRAS_CTRL_START 0
`define DRAS_CTRL_STORE 1
`define DRAS_CTRL_ECC 2
`define DRAS_CTRL_SPAN_LSB 4
`define DRAS_CTRL_ITC_LSB 8

// limit register fields
`define DRAS_LIMIT_DATA_LSB 0
`define DRAS_LIMIT_REPOS_LSB 8

// geometry register fields
`define DRAS_GEOM_NSEC_LSB 0
`define DRAS_GEOM_HEADS_LSB 8
`define DRAS_GEOM_ONE_BASED 16
`define DRAS_GEOM_DRIVE_LSB 17
`define DRAS_GEOM_BUF_LSB 20

// reset values
`define DRAS_RST_DLIM 8'h04
`define DRAS_RST_SLIM 8'h02
`define DRAS_RST_NSEC 8'h20
`define DRAS_RST_NHEADS 5'h04
`define DRAS_RST_SPAN 4'h0
`define DRAS_RST_ITC 3'h0

// completion codes and warning bits
`define DRAS_ERR_OK 8'h00
`define DRAS_ERR_ECC 8'h06
`define DRAS_ERR_DATA 8'h0c
`define DRAS_ERR_SEEK 8'h0d
`define DRAS_DET_CMP 0
`define DRAS_DET_CORR 1
`define DRAS_DET_DATA 2
`define DRAS_DET_SEEK 3

// autoboot
`define DRAS_STRAP_SETTLE 2'h3
`define DRAS_SECT_WINCH 8'h20
`define DRAS_SECT_FLOPPY 8'h10
`define DRAS_BUF_COUNT 5'h08
`define DRAS_BUF_BASE 16'h0800
`define DRAS_WS_BASE 17'h0_0169
`define DRAS_MSG_MIN 8'h02

`endif

// File: design/dras_pkg.sv
package dras_pkg;

  typedef enum logic [3:0] {
    S_STRAP, S_IDLE, S_MAP, S_ISSUE, S_WAIT, S_EXAM, S_SEND, S_JUMP, S_RUN, S_HALT
  } dras_state_t;

  typedef enum logic [2:0] {
    PH_INIT, PH_HOME, PH_RESTORE, PH_SEEK, PH_XFER, PH_CORRECT
  } dras_phase_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_SELECT_INIT, OP_RESTORE, OP_SEEK, OP_FETCH, OP_STORE, OP_CORRECT
  } dras_op_kind_t;

  typedef struct packed {
    dras_op_kind_t kind;
    logic [2:0] drive;
    logic [15:0] cyl;
    logic [4:0] head;
    logic [7:0] sector;
    logic [3:0] buffer;
  } dras_op_t;

  typedef struct packed {
    logic id_timeout;
    logic compare_byte_mismatch;
    logic data_error;
    logic correct_failed;
  } dras_data_phase_status_t;

  typedef struct packed {
    logic [15:0] entry;
    logic [15:0] ws_top;
    logic [15:0] param1;
    logic [15:0] param2;
    logic [15:0] param3;
  } dras_boot_info_t;

  typedef struct packed {
    dras_state_t st;
    dras_phase_t ph;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] settle;
    logic boot;
    logic boot_load;
    logic [2:0] drive;
    logic store;
    logic ecc_sel;
    logic [3:0] span;
    logic [2:0] itc;
    logic [7:0] dlim;
    logic [7:0] slim;
    logic [23:0] lsec;
    logic [7:0] nsec;
    logic [4:0] nheads;
    logic one_based;
    logic [3:0] buf_sel;
    logic [23:0] rem;
    logic [4:0] head;
    logic [15:0] cyl;
    logic [7:0] sector;
    logic [7:0] scnt;
    logic [7:0] kcnt;
    logic sflag;
    logic kflag;
    logic cmpflag;
    logic [31:0] syn;
    logic have_syn;
    logic [7:0] err_code;
    logic [7:0] detail;
    logic busy;
    logic error_pin;
    logic halted;
    logic running;
    dras_op_t op;
    logic op_req;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [8:0] idx;
    logic [8:0] cap_idx;
    logic [8:0] nload;
    logic [8:0] kload;
    logic [4:0] nfree;
    logic boot_jump;
    dras_boot_info_t info;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
  } dras_regs_t;

endpackage

// File: design/dras_top.sv
`timescale 1ns/10ps
`include "dras_consts.svh"

// Contract
// R1 - sector retry only when ID found and data error is neither timeout nor compare mismatch; code retries even with compare mismatch set
// R2 - qualifying data error reissues the same operation at once unless correcting
// R3 - data retry limit bounds sector retries; zero disables them
// R4 - ECC correction tried only after two equal syndromes, needing one retry
// R5 - ID search timeout causes restore, re-seek, then a new attempt
// R6 - reposition retry limit bounds seek retries; zero disables them
// R7 - each seek retry clears the sector retry count
// R8 - hardware retries off unless index timeout count is 1 to 7; unlogged; code retries at any count, 0 included
// R9 - at reset, low boot request pin starts autoboot
// R10 - two drive code pins pick drive 1 to 4 and its type
// R11 - autoboot selects, initialises, restores, then reads cylinder 0 head 0 sector 1
// R12 - failed boot sector read raises error pin and halts
// R13 - first byte 2 to 255 sends it plus that many bytes on link 0
// R14 - first byte 0 or 1 marks a self-boot descriptor; byte 1 ignored
// R15 - descriptor bytes 2-7 give code length, entry offset, workspace words
// R16 - descriptor bytes 8-13 give three parameters for the boot code
// R17 - code loads from logical sector 1 into top of buffer; must fit
// R18 - on good load and workspace, jump with parameters; any error halts
// R19 - boot code returning control makes the device halt
// R20 - workspace is 361 words plus 128 per free buffer, below the code
// R21 - board supplies 20 MHz or 16 MHz write clock for autoboot
// R22 - exhausted limits end with code 0x0C or 0x0D and zero detail
// R23 - success detail sets bit 2 for sector and bit 3 for seek retries
// R24 - logical sectors advance sector first, then head, then cylinder
// R25 - both retry counts clear at start of each sector command
// R26 - boot message bytes go in sector order from length byte, unframed
module dras_top
  import dras_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] head_choice_lines,
  output dras_op_t op_cmd,
  output logic op_req,
  input wire logic op_done,
  input wire dras_data_phase_status_t data_phase_status,
  input wire logic [31:0] op_syndrome,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [2:0] index_timeout_count,
  output logic boot_jump,
  output dras_boot_info_t boot_info,
  input wire logic boot_return,
  output logic error_pin
);

  dras_regs_t r;
  dras_regs_t n;
  logic [7:0] mem [0:255];
  logic cap_en;
  logic accept;
  logic [31:0] rdv;
  logic fin;
  logic [7:0] fcode;
  logic [7:0] fdet;
  logic [15:0] code_len;
  logic [8:0] nload_w;
  logic [16:0] ws_avail;
  logic [15:0] code_base;

  // reset both retry counters and begin mapping a logical sector
  function automatic dras_regs_t start_xfer(dras_regs_t s, logic [23:0] lsn, logic [3:0] bufi);
    dras_regs_t t;
    t = s;
    t.rem = lsn;
    t.head = '0;
    t.cyl = '0;
    t.buf_sel = bufi;
    t.scnt = '0; // R25
    t.kcnt = '0; // R25
    t.sflag = 1'h0;
    t.kflag = 1'h0;
    t.cmpflag = 1'h0;
    t.have_syn = 1'h0;
    t.st = S_MAP;
    return t;
  endfunction

  assign accept = hsel && htrans[1] && hready;
  assign cap_en = (r.st == S_WAIT) && (r.ph == PH_XFER) && r.boot && !r.boot_load && rd_valid && !r.cap_idx[8];
  assign code_len = {mem[3], mem[2]}; // R15
  assign nload_w = 9'((17'(code_len) + 17'h0_00ff) >> 8);
  assign ws_avail = `DRAS_WS_BASE + {5'h00, r.nfree, 7'h00}; // R20
  assign code_base = `DRAS_BUF_BASE + {3'h0, r.nfree, 8'h00};

  always_comb begin
    rdv = '0;
    if (haddr[31:8] != 24'h00_0000) begin
      rdv = '0;
    end else if (haddr[7:0] == `DRAS_OFF_CTRL) begin
      rdv[`DRAS_CTRL_STORE] = r.store;
      rdv[`DRAS_CTRL_ECC] = r.ecc_sel;
      rdv[`DRAS_CTRL_SPAN_LSB +: 4] = r.span;
      rdv[`DRAS_CTRL_ITC_LSB +: 3] = r.itc;
    end else if (haddr[7:0] == `DRAS_OFF_LIMIT) begin
      rdv[`DRAS_LIMIT_DATA_LSB +: 8] = r.dlim;
      rdv[`DRAS_LIMIT_REPOS_LSB +: 8] = r.slim;
    end else if (haddr[7:0] == `DRAS_OFF_LSEC) begin
      rdv[23:0] = r.lsec;
    end else if (haddr[7:0] == `DRAS_OFF_GEOM) begin
      rdv[`DRAS_GEOM_NSEC_LSB +: 8] = r.nsec;
      rdv[`DRAS_GEOM_HEADS_LSB +: 5] = r.nheads;
      rdv[`DRAS_GEOM_ONE_BASED] = r.one_based;
      rdv[`DRAS_GEOM_DRIVE_LSB +: 3] = r.drive;
      rdv[`DRAS_GEOM_BUF_LSB +: 4] = r.buf_sel;
    end else if (haddr[7:0] == `DRAS_OFF_STATUS) begin
      rdv = {8'h00, r.detail, r.err_code, 4'h0, r.running, r.halted, r.error_pin, r.busy};
    end else if (haddr[7:0] == `DRAS_OFF_RETRY) begin
      rdv = {16'h0000, r.kcnt, r.scnt};
    end
  end

  always_comb begin
    n = r;
    fin = 1'h0;
    fcode = `DRAS_ERR_OK;
    fdet = 8'h00;
    n.op_req = 1'h0;
    n.boot_jump = 1'h0;
    n.sync1 = head_choice_lines;
    n.sync2 = r.sync1;
    n.a_wr = accept && hwrite;
    if (accept) begin
      n.a_addr = haddr[31:8] == 24'h00_0000 ? haddr[7:0] : 8'hff;
    end
    if (accept && !hwrite) begin
      n.hrdata = rdv;
    end
    if (cap_en) begin
      n.cap_idx = 9'(r.cap_idx + 9'h001);
    end
    // register writes land in the data phase
    if (r.a_wr) begin
      if (r.a_addr == `DRAS_OFF_CTRL) begin
        n.store = hwdata[`DRAS_CTRL_STORE];
        n.ecc_sel = hwdata[`DRAS_CTRL_ECC];
        n.span = hwdata[`DRAS_CTRL_SPAN_LSB +: 4];
        n.itc = hwdata[`DRAS_CTRL_ITC_LSB +: 3]; // R8
        if (hwdata[`DRAS_CTRL_START] && (r.st == S_IDLE)) begin
          n = start_xfer(n, r.lsec, r.buf_sel);
          n.busy = 1'h1;
          n.err_code = `DRAS_ERR_OK;
          n.detail = 8'h00;
        end
      end else if (r.a_addr == `DRAS_OFF_LIMIT) begin
        n.dlim = hwdata[`DRAS_LIMIT_DATA_LSB +: 8];
        n.slim = hwdata[`DRAS_LIMIT_REPOS_LSB +: 8];
      end else if (r.a_addr == `DRAS_OFF_LSEC) begin
        n.lsec = hwdata[23:0];
      end else if (r.a_addr == `DRAS_OFF_GEOM) begin
        n.nsec = hwdata[`DRAS_GEOM_NSEC_LSB +: 8];
        n.nheads = hwdata[`DRAS_GEOM_HEADS_LSB +: 5];
        n.one_based = hwdata[`DRAS_GEOM_ONE_BASED];
        n.drive = hwdata[`DRAS_GEOM_DRIVE_LSB +: 3];
        n.buf_sel = hwdata[`DRAS_GEOM_BUF_LSB +: 4];
      end
    end

    case (r.st)
      S_STRAP: begin
        n.settle = 2'(r.settle + 2'h1);
        if (r.settle == `DRAS_STRAP_SETTLE) begin
          if (!r.sync2[2]) begin // R9
            n.boot = 1'h1;
            n.busy = 1'h1;
            n.drive = 3'(3'h4 - {1'h0, r.sync2[1:0]}); // R10
            n.nsec = r.sync2[1] ? `DRAS_SECT_WINCH : `DRAS_SECT_FLOPPY; // R10
            n.one_based = 1'h1;
            n.ph = PH_INIT; // R11
            n.st = S_ISSUE;
          end else begin
            n.st = S_IDLE;
          end
        end
      end
      S_IDLE: begin
      end
      S_MAP: begin
        if ((r.nsec != 8'h00) && (r.rem >= 24'(r.nsec))) begin // R24
          n.rem = 24'(r.rem - 24'(r.nsec));
          if (5'(r.head + 5'h01) >= r.nheads) begin
            n.head = '0;
            n.cyl = 16'(r.cyl + 16'h0001);
          end else begin
            n.head = 5'(r.head + 5'h01);
          end
        end else begin
          n.sector = 8'(r.rem[7:0] + {7'h00, r.one_based});
          n.ph = PH_XFER;
          n.st = S_ISSUE;
        end
      end
      S_ISSUE: begin
        n.op_req = 1'h1;
        n.op.drive = r.drive;
        n.op.cyl = r.ph >= PH_SEEK ? r.cyl : 16'h0000;
        n.op.head = r.head;
        n.op.sector = r.sector;
        n.op.buffer = r.buf_sel;
        case (r.ph)
          PH_INIT: n.op.kind = OP_SELECT_INIT;
          PH_HOME: n.op.kind = OP_RESTORE;
          PH_RESTORE: n.op.kind = OP_RESTORE; // R5
          PH_SEEK: n.op.kind = OP_SEEK; // R5
          PH_XFER: n.op.kind = (r.store && !r.boot) ? OP_STORE : OP_FETCH;
          default: n.op.kind = OP_CORRECT;
        endcase
        n.cap_idx = '0;
        n.st = S_WAIT;
      end
      S_WAIT: begin
        if (op_done) begin
          case (r.ph)
            PH_INIT: begin
              n.ph = PH_HOME; // R11
              n.st = S_ISSUE;
            end
            PH_HOME: begin
              n = start_xfer(n, 24'h00_0000, 4'h0); // R11
            end
            PH_RESTORE: begin
              n.ph = PH_SEEK; // R5
              n.st = S_ISSUE;
            end
            PH_SEEK: begin
              n.ph = PH_XFER; // R5
              n.st = S_ISSUE;
            end
            PH_XFER: begin
              if (data_phase_status.id_timeout) begin
                if (r.kcnt < r.slim) begin // R6
                  n.kcnt = 8'(r.kcnt + 8'h01);
                  n.kflag = 1'h1;
                  n.scnt = '0; // R7
                  n.have_syn = 1'h0;
                  n.ph = PH_RESTORE; // R5
                  n.st = S_ISSUE;
                end else begin
                  fin = 1'h1;
                  fcode = `DRAS_ERR_SEEK; // R22
                end
              end else if (data_phase_status.data_error) begin // R1
                if (r.ecc_sel && (r.span != 4'h0) && r.have_syn && (r.syn == op_syndrome) &&
                    (op_syndrome != 32'h0000_0000)) begin // R4
                  n.ph = PH_CORRECT;
                  n.st = S_ISSUE;
                end else if (r.scnt < r.dlim) begin // R3
                  n.scnt = 8'(r.scnt + 8'h01);
                  n.sflag = 1'h1;
                  n.syn = op_syndrome;
                  n.have_syn = 1'h1;
                  n.st = S_ISSUE; // R2
                end else begin
                  fin = 1'h1;
                  fcode = `DRAS_ERR_DATA; // R22
                end
              end else begin
                fin = 1'h1;
                fdet[`DRAS_DET_CMP] = data_phase_status.compare_byte_mismatch;
                fdet[`DRAS_DET_DATA] = r.sflag; // R23
                fdet[`DRAS_DET_SEEK] = r.kflag; // R23
              end
            end
            default: begin
              fin = 1'h1;
              if (data_phase_status.correct_failed) begin
                fcode = `DRAS_ERR_ECC;
              end else begin
                fdet[`DRAS_DET_CORR] = 1'h1;
                fdet[`DRAS_DET_DATA] = r.sflag;
                fdet[`DRAS_DET_SEEK] = r.kflag;
              end
            end
          endcase
        end
      end
      S_EXAM: begin
        if (mem[0] >= `DRAS_MSG_MIN) begin // R13
          n.idx = '0;
          n.tx_valid = 1'h1;
          n.tx_data = mem[0]; // R26
          n.st = S_SEND;
        end else if (nload_w > {4'h0, `DRAS_BUF_COUNT}) begin // R17
          n.error_pin = 1'h1;
          n.halted = 1'h1;
          n.st = S_HALT;
        end else begin // R14
          n.nload = nload_w;
          n.nfree = 5'(`DRAS_BUF_COUNT - nload_w[4:0]);
          n.kload = '0;
          n.boot_load = 1'h1;
          if (nload_w == 9'h000) begin
            n.st = S_JUMP;
          end else begin
            n = start_xfer(n, 24'h00_0001, 4'(`DRAS_BUF_COUNT - nload_w[4:0])); // R17
          end
        end
      end
      S_SEND: begin
        if (r.tx_valid && tx_ready) begin
          if (r.idx[7:0] == mem[0]) begin
            n.tx_valid = 1'h0;
            n.boot = 1'h0;
            n.busy = 1'h0;
            n.st = S_IDLE;
          end else begin
            n.idx = 9'(r.idx + 9'h001);
            n.tx_data = mem[8'(r.idx + 9'h001)]; // R26
          end
        end
      end
      S_JUMP: begin
        if (17'({mem[7], mem[6]}) <= ws_avail) begin // R18
          n.boot_jump = 1'h1;
          n.info.entry = 16'(code_base + {mem[5], mem[4]});
          n.info.ws_top = code_base; // R20
          n.info.param1 = {mem[9], mem[8]}; // R16
          n.info.param2 = {mem[11], mem[10]};
          n.info.param3 = {mem[13], mem[12]};
          n.running = 1'h1;
          n.st = S_RUN;
        end else begin
          n.error_pin = 1'h1; // R18
          n.halted = 1'h1;
          n.st = S_HALT;
        end
      end
      S_RUN: begin
        if (boot_return) begin
          n.running = 1'h0;
          n.halted = 1'h1; // R19
          n.st = S_HALT;
        end
      end
      default: begin
      end
    endcase

    if (fin) begin
      if (r.boot) begin
        if (fcode != `DRAS_ERR_OK) begin
          n.error_pin = 1'h1; // R12
          n.halted = 1'h1;
          n.st = S_HALT;
        end else if (!r.boot_load) begin
          n.st = S_EXAM;
        end else if (9'(r.kload + 9'h001) == r.nload) begin
          n.st = S_JUMP;
        end else begin
          n.kload = 9'(r.kload + 9'h001);
          n = start_xfer(n, 24'(r.kload + 9'h002), 4'(r.buf_sel + 4'h1)); // R17
        end
      end else begin
        n.err_code = fcode;
        n.detail = fdet;
        n.busy = 1'h0;
        n.st = S_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.st <= S_STRAP;
      r.ph <= PH_INIT;
      r.op.kind <= OP_NONE;
      r.dlim <= `DRAS_RST_DLIM;
      r.slim <= `DRAS_RST_SLIM;
      r.nsec <= `DRAS_RST_NSEC;
      r.nheads <= `DRAS_RST_NHEADS;
      r.span <= `DRAS_RST_SPAN;
      r.itc <= `DRAS_RST_ITC;
    end else begin
      r <= n;
    end
  end

  // sector bytes of the boot sector, kept for message and descriptor
  always_ff @(posedge hclk) begin
    if (cap_en) begin
      mem[r.cap_idx[7:0]] <= rd_data;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign op_cmd = r.op;
  assign op_req = r.op_req;
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign index_timeout_count = r.itc; // R8
  assign boot_jump = r.boot_jump;
  assign boot_info = r.info;
  assign error_pin = r.error_pin;

endmodule

// File: dv/dras_top_checker.sv
`timescale 1ns/10ps
module dras_top_checker
  import dras_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] head_choice_lines,
  input wire dras_op_t op_cmd,
  input wire logic op_req,
  input wire logic op_done,
  input wire dras_data_phase_status_t data_phase_status,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic boot_jump,
  input wire logic error_pin
);
  dras_op_t last;
  logic [1:0] nreq;
  logic boot;
  assign boot = !head_choice_lines[2];
  // last issued op and how many ops since reset, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= '0;
      nreq <= 2'h0;
    end else if (op_req) begin
      last <= op_cmd;
      nreq <= nreq + {1'b0, nreq != 2'h3};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_retry_same;
    (op_done && data_phase_status.data_error && !data_phase_status.id_timeout) ##[1:4] op_req
      |-> {op_cmd.cyl, op_cmd.head, op_cmd.sector} == {last.cyl, last.head, last.sector};
  endproperty
  a_retry_same: assert property (p_retry_same) else $error("retry went elsewhere");
  property p_reseek;
    (op_done && data_phase_status.id_timeout) ##[1:4] op_req |-> op_cmd.kind == OP_RESTORE;
  endproperty
  a_reseek: assert property (p_reseek) else $error("no restore after id timeout");
  property p_boot_drive;
    op_req && boot |-> op_cmd.drive == 3'h4 - {1'b0, head_choice_lines[1:0]};
  endproperty
  a_boot_drive: assert property (p_boot_drive) else $error("wrong boot drive");
  property p_boot_first;
    op_req && boot && nreq == 2'h0 |-> op_cmd.kind == OP_SELECT_INIT;
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("boot did not select first");
  property p_boot_read;
    op_req && boot && nreq == 2'h2 |-> op_cmd.kind == OP_FETCH && op_cmd.cyl == 16'h0000
      && op_cmd.head == 5'h00 && op_cmd.sector == 8'h01;
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("wrong boot sector");
  property p_err_sticky;
    error_pin |=> error_pin;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error pin dropped");
  property p_jump_clean;
    boot_jump |-> !error_pin ##1 !boot_jump;
  endproperty
  a_jump_clean: assert property (p_jump_clean) else $error("bad boot jump");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("link byte lost");
endmodule

bind dras_top dras_top_checker dras_top_checker_i (.*);

// File: dv/dras_disk_model.sv
`timescale 1ns/10ps
module dras_disk_model
  import dras_pkg::*;
(
  input wire logic hclk,
  input wire dras_op_t op_cmd,
  input wire logic op_req,
  output logic op_done,
  output dras_data_phase_status_t data_phase_status,
  output logic [31:0] op_syndrome,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] sec0 [256];
  logic [35:0] script [$];
  logic [7:0] rx [$];
  dras_op_t seen [$];
  logic stall = 0;
  logic [35:0] s;
  logic [3:0] cnt;
  // disk side: one op at a time, latency varies 1 to 8 cycles
  initial begin
    {op_done, rd_valid, data_phase_status, op_syndrome, rd_data} = '0;
    forever begin
      @(posedge hclk);
      op_done <= 0;
      rd_valid <= 0;
      rd_data <= ~rd_data;
      {data_phase_status, op_syndrome} <= ~{data_phase_status, op_syndrome};
      if (op_req) begin
        seen.push_back(op_cmd);
        s = script.size() > 0 ? script.pop_front() : 36'h0;
        repeat (cnt[2:0] + 1) @(posedge hclk);
        if (op_cmd.kind == OP_FETCH) begin
          for (int i = 0; i < 256; i++) begin
            rd_valid <= 1;
            rd_data <= ({op_cmd.cyl, op_cmd.head, op_cmd.sector} == 29'h1) ? sec0[i] : i[7:0] ^ op_cmd.sector;
            @(posedge hclk);
          end
        end
        rd_valid <= 0;
        op_done <= 1;
        {data_phase_status, op_syndrome} <= s;
      end
    end
  end
  // link receiver, stalls half the cycles if asked
  initial begin
    tx_ready = 0;
    cnt = 0;
    forever begin
      @(posedge hclk);
      if (tx_valid && tx_ready) rx.push_back(tx_data);
      cnt <= cnt + 1;
      tx_ready <= !stall || cnt[1];
    end
  end
endmodule

// File: dv/dras_top_tb.sv
`timescale 1ns/10ps
`define MD dras_disk_model_i
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %h got %h", n, e, g); end end
module dras_top_tb;
  import dras_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, op_req, op_done, rd_valid;
  logic tx_valid, tx_ready, boot_jump, boot_return, error_pin;
  logic [31:0] haddr, hwdata, hrdata, op_syndrome, r;
  logic [1:0] htrans;
  logic [2:0] hsize, head_choice_lines, index_timeout_count;
  logic [7:0] rd_data, tx_data;
  dras_op_t op_cmd;
  dras_data_phase_status_t data_phase_status;
  dras_boot_info_t boot_info;
  int mismatches, check_count;
  assign hready = hreadyout;
  dras_top dras_top_i (.*);
  dras_disk_model dras_disk_model_i (.*);
  initial begin
    hclk = 0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
  task automatic rst(input logic [2:0] s);
    hresetn <= 0;
    head_choice_lines <= s;
    `MD.script.delete();
    `MD.seen.delete();
    `MD.rx.delete();
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic sc(input logic [3:0] st, input logic [31:0] sy);
    `MD.script.push_back({st, sy});
  endtask
  // start one sector command and poll status until it is no longer busy
  task automatic cmd(input logic [31:0] ctrl, lim, input logic [7:0] code, det, input int nops);
    logic [31:0] q;
    `MD.seen.delete();
    ahb(1'b1, 32'h0000_0004, lim, q);
    ahb(1'b1, 32'h0000_0000, ctrl | 32'h0000_0001, q);
    for (int i = 0; i < 2000; i++) begin
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000, q);
      if (q[0] === 1'b0) break;
    end
    `CHK("code", code, q[15:8])
    `CHK("detail", det, q[23:16])
    `CHK("ops", nops, `MD.seen.size())
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic t_regs();
    rst(3'h7);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
    `CHK("limit", 32'h0000_0204, r)
    ahb(1'b0, 32'h0000_000c, 32'h0000_0000, r);
    `CHK("geom", 32'h0000_0420, r)
    ahb(1'b1, 32'h0000_0040, 32'hffff_fff0, r);
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000, r);
    `CHK("unmapped", 32'h0000_0000, r)
    `CHK("itc0", 3'h0, index_timeout_count)
  endtask
  task automatic t_retry();
    dras_op_t o;
    ahb(1'b1, 32'h0000_0008, 32'h0000_00a5, r);
    sc(4'h2, 32'h0000_0011);
    sc(4'h8, 32'h0000_0000);
    sc(4'h0, 32'h0000_0000);
    sc(4'h0, 32'h0000_0000);
    sc(4'h2, 32'h0000_0022);
    cmd(32'h0000_0300, 32'h0000_0101, 8'h00, 8'h0c, 6);
    o = `MD.seen[0];
    `CHK("map", {OP_FETCH, 16'h0001, 5'h01, 8'h05}, {o.kind, o.cyl, o.head, o.sector})
    `CHK("reseek", {OP_RESTORE, OP_SEEK, OP_FETCH}, {`MD.seen[2].kind, `MD.seen[3].kind, `MD.seen[4].kind})
    `CHK("itc", 3'h3, index_timeout_count)
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000, r);
    `CHK("retries", 32'h0000_0101, r)
    cmd(32'h0000_0000, 32'h0000_0101, 8'h00, 8'h00, 1);
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000, r);
    `CHK("cleared", 32'h0000_0000, r)
  endtask
  task automatic t_exhaust();
    sc(4'h2, 32'h0000_0001);
    sc(4'h2, 32'h0000_0002);
    cmd(32'h0000_0002, 32'h0000_0001, 8'h0c, 8'h00, 2);
    `CHK("store", OP_STORE, `MD.seen[0].kind)
    sc(4'h8, 32'h0000_0000);
    cmd(32'h0000_0000, 32'h0000_0000, 8'h0d, 8'h00, 1);
    sc(4'h8, 32'h0000_0000);
    sc(4'h0, 32'h0000_0000);
    sc(4'h0, 32'h0000_0000);
    sc(4'h8, 32'h0000_0000);
    cmd(32'h0000_0000, 32'h0000_0100, 8'h0d, 8'h00, 4);
    sc(4'h2, 32'h0000_0003);
    cmd(32'h0000_0000, 32'h0000_0100, 8'h0c, 8'h00, 1);
    sc(4'h4, 32'h0000_0000);
    cmd(32'h0000_0000, 32'h0000_0000, 8'h00, 8'h01, 1);
  endtask
  task automatic t_ecc();
    for (int k = 0; k < 3; k++) begin
      sc(4'h2, 32'h0000_00ab);
      sc(4'h2, 32'h0000_00ab);
      sc(k == 1 ? 4'h1 : 4'h0, 32'h0000_0000);
    end
    cmd(32'h0000_0014, 32'h0000_0003, 8'h00, 8'h06, 3);
    `CHK("correct", OP_CORRECT, `MD.seen[2].kind)
    cmd(32'h0000_0014, 32'h0000_0003, 8'h06, 8'h00, 3);
    // zero span: equal syndromes must not lead to a correction
    `MD.script.delete();
    sc(4'h2, 32'h0000_00ab);
    sc(4'h2, 32'h0000_00ab);
    cmd(32'h0000_0004, 32'h0000_0001, 8'h0c, 8'h00, 2);
  endtask
  task automatic t_boot_msg();
    for (int i = 0; i < 256; i++) `MD.sec0[i] = 8'(i * 7 + 3);
    `MD.sec0[0] = 8'hff;
    `MD.stall = 1;
    rst(3'h2);
    for (int i = 0; i < 5000 && `MD.rx.size() < 256; i++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    `CHK("nbytes", 256, `MD.rx.size())
    for (int i = 0; i < 256; i++) `CHK("byte", `MD.sec0[i], `MD.rx[i])
    `CHK("drive", 3'h2, `MD.seen[0].drive)
    `MD.stall = 0;
  endtask
  task automatic t_boot_fail();
    rst(3'h0);
    sc(4'h0, 32'h0000_0000);
    sc(4'h0, 32'h0000_0000);
    for (int i = 0; i < 5; i++) sc(4'h2, 32'(i + 1));
    for (int i = 0; i < 5000 && !error_pin; i++) @(posedge hclk);
    `CHK("errpin", 1'b1, error_pin)
    `CHK("tries", 7, `MD.seen.size())
    `CHK("drive4", 3'h4, `MD.seen[0].drive)
    `CHK("silent", 0, `MD.rx.size())
  endtask
  task automatic t_self_boot(input logic [15:0] ws);
    logic [111:0] d;
    d = {7'h00, ws[0], 8'hee, 16'h0002, 16'h1000, ws[7:0], ws[15:8], 48'h3412_7856_bc9a};
    for (int i = 0; i < 14; i++) `MD.sec0[i] = d[111 - 8 * i -: 8];
    rst(3'h3);
    for (int i = 0; i < 5000 && !boot_jump && !error_pin; i++) @(posedge hclk);
    if (ws == 16'h0469) begin
      `CHK("info", {16'h0e10, 16'h0e00, 48'h1234_5678_9abc}, boot_info)
      `CHK("load", {8'h02, 4'h6, 8'h03, 4'h7}, {`MD.seen[3].sector, `MD.seen[3].buffer, `MD.seen[4].sector, `MD.seen[4].buffer})
      boot_return <= 1;
      repeat (4) @(posedge hclk);
      boot_return <= 0;
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
      `CHK("halted", 1'b1, r[2])
    end
    `CHK("wsfit", ws != 16'h0469, error_pin)
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, boot_return} = '0;
    hsize = 3'h2;
    head_choice_lines = 3'h7;
    t_regs();
    t_retry();
    t_exhaust();
    t_ecc();
    t_boot_msg();
    t_boot_fail();
    t_self_boot(16'h0469);
    t_self_boot(16'h046a);
    finish_test();
  end
endmodule
